/* smsel_bit_src.sv */
module smsel_bit_src
(
    // clock and control
    input wire logic clock,
    input wire logic run,
    // bit streams toward the block
    output logic     v_tx = 1'b0,
    output logic     b_tx = 1'b0,
    output logic     v_rx = 1'b0,
    output logic     b_rx = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int          seed = 39588;
    logic [31:0] r;

    // random gaps make slow and back-to-back bits; data lines take a new random value every cycle
    always @(posedge clock)
    begin
        r = $random(seed);
        v_tx <= run & (r[3:2] != 2'h0);
        b_tx <= r[4];
        v_rx <= run & (r[6:5] != 2'h0);
        b_rx <= r[7];
    end
endmodule // smsel_bit_src

/* smsel_pkg.sv */
package smsel_pkg;
    typedef logic [2:0] smsel_mode_t;
    typedef enum logic [2:0] {
        SMSEL_K_SELF_SAT,
        SMSEL_K_SELF_V35,
        SMSEL_K_MUX_SYNC,
        SMSEL_K_RS_SYNC,
        SMSEL_K_TURBO_SYNC
    } smsel_kind_e;
endpackage

/* smsel_regs.svh */
`ifndef SMSEL_REGS_SVH
`define SMSEL_REGS_SVH

// register byte offsets
`define SMSEL_OFS_TX_MODE   8'h00
`define SMSEL_OFS_RX_MODE   8'h04
`define SMSEL_OFS_OPTIONS   8'h08
`define SMSEL_OFS_STATUS    8'h0C
`define SMSEL_OFS_TX_CHG    8'h10
`define SMSEL_OFS_RX_CHG    8'h14

// scrambler mode codes
`define SMSEL_MODE_AUTO     3'h0
`define SMSEL_MODE_S308     3'h1
`define SMSEL_MODE_S309     3'h2
`define SMSEL_MODE_V35      3'h3
`define SMSEL_MODE_SAT      3'h4
`define SMSEL_MODE_ALT_V35  3'h5
`define SMSEL_MODE_ALT_SAT  3'h6
`define SMSEL_MODE_TURBO    3'h7
`define SMSEL_MODE_RESET    3'h0

// options fields: rx group sits at tx position plus 8
`define SMSEL_OPT_TURBO     0
`define SMSEL_OPT_MUX       1
`define SMSEL_OPT_RS        2
`define SMSEL_OPT_AUTO309   3
`define SMSEL_OPT_RX_BASE   8
`define SMSEL_OPT_RESET     32'h0000_0000

// status fields
`define SMSEL_ST_TX_KIND    0
`define SMSEL_ST_TX_INV     3
`define SMSEL_ST_RX_KIND    8
`define SMSEL_ST_RX_INV     11
`define SMSEL_ST_HAS_TURBO  16
`define SMSEL_ST_HAS_MUX    17
`define SMSEL_ST_HAS_RS     18

`endif

/* smsel_resolve.sv */
`include "smsel_regs.svh"

module smsel_resolve
    import smsel_pkg::*;
(
    // one link direction
    smsel_sel_if.resolver sel
);
    smsel_mode_t eff_mode;

    always_comb
    begin
        eff_mode = sel.mode;
        if (sel.mode == `SMSEL_MODE_AUTO)
        begin
            if (!sel.turbo_on)
                eff_mode = sel.auto_309 ? `SMSEL_MODE_S309 : `SMSEL_MODE_S308;
            else if (!sel.mux_on)
                eff_mode = `SMSEL_MODE_TURBO;
            else
                eff_mode = `SMSEL_MODE_S308;
        end
    end

    always_comb
    begin
        case (eff_mode)
            `SMSEL_MODE_S308:
            begin
                if (sel.mux_on)
                    sel.kind = SMSEL_K_MUX_SYNC;
                else if (sel.rs_on)
                    sel.kind = SMSEL_K_RS_SYNC;
                else
                    sel.kind = SMSEL_K_SELF_SAT;
            end
            `SMSEL_MODE_S309:
                sel.kind = sel.mux_on ? SMSEL_K_MUX_SYNC : SMSEL_K_SELF_SAT;
            `SMSEL_MODE_V35,
            `SMSEL_MODE_ALT_V35:
                sel.kind = SMSEL_K_SELF_V35;
            `SMSEL_MODE_SAT,
            `SMSEL_MODE_ALT_SAT:
                sel.kind = SMSEL_K_SELF_SAT;
            `SMSEL_MODE_TURBO:
                sel.kind = SMSEL_K_TURBO_SYNC;
            default:
                sel.kind = SMSEL_K_SELF_SAT;
        endcase
    end

    // inversion keys on the programmed mode, never on auto's choice
    assign sel.invert = (sel.mode == `SMSEL_MODE_ALT_V35) ||
                        (sel.mode == `SMSEL_MODE_ALT_SAT);

endmodule // smsel_resolve

/* smsel_sel_if.sv */
interface smsel_sel_if;
    import smsel_pkg::*;
    smsel_mode_t mode;
    logic        auto_309;
    logic        turbo_on;
    logic        mux_on;
    logic        rs_on;
    smsel_kind_e kind;
    logic        invert;
    modport owner (output mode, auto_309, turbo_on, mux_on, rs_on, input kind, invert);
    modport resolver (input mode, auto_309, turbo_on, mux_on, rs_on, output kind, invert);
endinterface

/* smsel_top.sv */
`include "smsel_regs.svh"

module smsel_top
    import smsel_pkg::*;
#(
    parameter bit HAS_TURBO = 1'b1,
    parameter bit HAS_MUX   = 1'b1,
    parameter bit HAS_RS    = 1'b1,
    parameter int CNT_W     = 16
)
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // transmit bit stream
    input  wire logic        tx_bit_valid,
    input  wire logic        tx_bit_in,
    output logic             tx_bit_valid_out,
    output logic             tx_bit_out,
    output logic      [2:0]  tx_scr_kind,
    output logic             tx_scr_invert,
    // receive bit stream
    input  wire logic        rx_bit_valid,
    input  wire logic        rx_bit_in,
    output logic             rx_bit_valid_out,
    output logic             rx_bit_out,
    output logic      [2:0]  rx_scr_kind,
    output logic             rx_scr_invert
);

    logic [1:0]       rst_sync_ff;
    logic             rst_n;

    logic             acc;
    logic             wr_pend_ff;
    logic             rd_wait_ff;
    logic [7:0]       addr_ff;
    logic [31:0]      hrdata_ff;
    logic [31:0]      nxt_hrdata;

    smsel_mode_t      tx_mode_ff;
    smsel_mode_t      rx_mode_ff;
    logic [31:0]      opt_ff;

    smsel_kind_e      tx_kind_ff;
    smsel_kind_e      rx_kind_ff;
    logic             tx_inv_ff;
    logic             rx_inv_ff;
    logic             tx_vld_ff;
    logic             rx_vld_ff;
    logic             tx_dat_ff;
    logic             rx_dat_ff;

    logic [CNT_W-1:0] tx_chg_ff;
    logic [CNT_W-1:0] rx_chg_ff;
    logic [CNT_W-1:0] nxt_tx_chg;
    logic [CNT_W-1:0] nxt_rx_chg;
    logic             tx_chg_ev;
    logic             rx_chg_ev;
    logic             tx_chg_clr;
    logic             rx_chg_clr;
    logic [31:0]      status;

    smsel_sel_if tx_sel ();
    smsel_sel_if rx_sel ();

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end

    assign rst_n = rst_sync_ff[1];

    // bus slave: writes take no wait, reads take one
    assign acc       = hsel && htrans[1] && hready;
    assign hreadyout = !rd_wait_ff;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_ff <= 1'b0;
            rd_wait_ff <= 1'b0;
            addr_ff    <= 8'h00;
        end
        else
        begin
            wr_pend_ff <= acc && hwrite;
            rd_wait_ff <= acc && !hwrite;
            if (acc)
                addr_ff <= haddr[7:0];
        end
    end

    // read data is sampled one cycle late so a preceding write is seen
    always_comb
    begin
        case ({addr_ff[7:2], 2'h0})
            `SMSEL_OFS_TX_MODE: nxt_hrdata = {29'h0, tx_mode_ff};
            `SMSEL_OFS_RX_MODE: nxt_hrdata = {29'h0, rx_mode_ff};
            `SMSEL_OFS_OPTIONS: nxt_hrdata = opt_ff;
            `SMSEL_OFS_STATUS:  nxt_hrdata = status;
            `SMSEL_OFS_TX_CHG:  nxt_hrdata = 32'(tx_chg_ff);
            `SMSEL_OFS_RX_CHG:  nxt_hrdata = 32'(rx_chg_ff);
            default:            nxt_hrdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            hrdata_ff <= 32'h0000_0000;
        else if (rd_wait_ff)
            hrdata_ff <= nxt_hrdata;
    end

    // configuration registers, one mode per direction
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_mode_ff <= `SMSEL_MODE_RESET;
            rx_mode_ff <= `SMSEL_MODE_RESET;
            opt_ff     <= `SMSEL_OPT_RESET;
        end
        else if (wr_pend_ff)
        begin
            case ({addr_ff[7:2], 2'h0})
                `SMSEL_OFS_TX_MODE: tx_mode_ff <= hwdata[2:0];
                `SMSEL_OFS_RX_MODE: rx_mode_ff <= hwdata[2:0];
                `SMSEL_OFS_OPTIONS: opt_ff <= hwdata;
                default:            opt_ff <= opt_ff;
            endcase
        end
    end

    assign tx_chg_clr = wr_pend_ff && ({addr_ff[7:2], 2'h0} == `SMSEL_OFS_TX_CHG);
    assign rx_chg_clr = wr_pend_ff && ({addr_ff[7:2], 2'h0} == `SMSEL_OFS_RX_CHG);

    // an option not fitted reads back as written but never takes effect
    assign tx_sel.mode     = tx_mode_ff;
    assign tx_sel.auto_309 = opt_ff[`SMSEL_OPT_AUTO309];
    assign tx_sel.turbo_on = HAS_TURBO && opt_ff[`SMSEL_OPT_TURBO];
    assign tx_sel.mux_on   = HAS_MUX && opt_ff[`SMSEL_OPT_MUX];
    assign tx_sel.rs_on    = HAS_RS && opt_ff[`SMSEL_OPT_RS];

    assign rx_sel.mode     = rx_mode_ff;
    assign rx_sel.auto_309 = opt_ff[`SMSEL_OPT_RX_BASE + `SMSEL_OPT_AUTO309];
    assign rx_sel.turbo_on = HAS_TURBO && opt_ff[`SMSEL_OPT_RX_BASE + `SMSEL_OPT_TURBO];
    assign rx_sel.mux_on   = HAS_MUX && opt_ff[`SMSEL_OPT_RX_BASE + `SMSEL_OPT_MUX];
    assign rx_sel.rs_on    = HAS_RS && opt_ff[`SMSEL_OPT_RX_BASE + `SMSEL_OPT_RS];

    smsel_resolve u_tx_resolve
    (
        .sel (tx_sel)
    );

    smsel_resolve u_rx_resolve
    (
        .sel (rx_sel)
    );

    // selection only moves on a bit boundary so no bit straddles two scramblers
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_kind_ff <= SMSEL_K_SELF_SAT;
            tx_inv_ff  <= 1'b0;
            tx_vld_ff  <= 1'b0;
            tx_dat_ff  <= 1'b0;
        end
        else
        begin
            tx_vld_ff <= tx_bit_valid;
            if (tx_bit_valid)
            begin
                tx_kind_ff <= tx_sel.kind;
                tx_inv_ff  <= tx_sel.invert;
                tx_dat_ff  <= tx_bit_in ^ tx_sel.invert;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_kind_ff <= SMSEL_K_SELF_SAT;
            rx_inv_ff  <= 1'b0;
            rx_vld_ff  <= 1'b0;
            rx_dat_ff  <= 1'b0;
        end
        else
        begin
            rx_vld_ff <= rx_bit_valid;
            if (rx_bit_valid)
            begin
                rx_kind_ff <= rx_sel.kind;
                rx_inv_ff  <= rx_sel.invert;
                rx_dat_ff  <= rx_bit_in ^ rx_sel.invert;
            end
        end
    end

    // change counters: a change in the clearing cycle still counts
    assign tx_chg_ev = tx_bit_valid &&
                       ((tx_sel.kind != tx_kind_ff) || (tx_sel.invert != tx_inv_ff));
    assign rx_chg_ev = rx_bit_valid &&
                       ((rx_sel.kind != rx_kind_ff) || (rx_sel.invert != rx_inv_ff));

    always_comb
    begin
        nxt_tx_chg = tx_chg_clr ? '0 : tx_chg_ff;
        if (tx_chg_ev && (nxt_tx_chg != '1))
            nxt_tx_chg = nxt_tx_chg + 1'b1;
        nxt_rx_chg = rx_chg_clr ? '0 : rx_chg_ff;
        if (rx_chg_ev && (nxt_rx_chg != '1))
            nxt_rx_chg = nxt_rx_chg + 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_chg_ff <= '0;
            rx_chg_ff <= '0;
        end
        else
        begin
            tx_chg_ff <= nxt_tx_chg;
            rx_chg_ff <= nxt_rx_chg;
        end
    end

    always_comb
    begin
        status = 32'h0000_0000;
        status[`SMSEL_ST_TX_KIND +: 3] = tx_kind_ff;
        status[`SMSEL_ST_TX_INV]       = tx_inv_ff;
        status[`SMSEL_ST_RX_KIND +: 3] = rx_kind_ff;
        status[`SMSEL_ST_RX_INV]       = rx_inv_ff;
        status[`SMSEL_ST_HAS_TURBO]    = HAS_TURBO;
        status[`SMSEL_ST_HAS_MUX]      = HAS_MUX;
        status[`SMSEL_ST_HAS_RS]       = HAS_RS;
    end

    assign tx_bit_valid_out = tx_vld_ff;
    assign tx_bit_out       = tx_dat_ff;
    assign tx_scr_kind      = tx_kind_ff;
    assign tx_scr_invert    = tx_inv_ff;
    assign rx_bit_valid_out = rx_vld_ff;
    assign rx_bit_out       = rx_dat_ff;
    assign rx_scr_kind      = rx_kind_ff;
    assign rx_scr_invert    = rx_inv_ff;

endmodule // smsel_top

/* smsel_top_sva.sv */
module smsel_top_sva
(
    // clock and reset
    input wire logic       clock,
    input wire logic       resetn,
    // bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    // streams
    input wire logic       tx_bit_valid,
    input wire logic       tx_bit_in,
    input wire logic       tx_bit_valid_out,
    input wire logic       tx_bit_out,
    input wire logic [2:0] tx_scr_kind,
    input wire logic       tx_scr_invert,
    input wire logic       rx_bit_valid,
    input wire logic       rx_bit_valid_out,
    input wire logic       rx_bit_out,
    input wire logic [2:0] rx_scr_kind,
    input wire logic       rx_scr_invert
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_acc;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    AST_RESP_OKAY: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    AST_WR_NO_WAIT: assert property (s_acc and hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_RD_ONE_WAIT: assert property (s_acc and !hwrite |=> s_rd_wait)
        else $error("read wait not one cycle");
    AST_TX_VALID_LAT: assert property (1'b1 |=> tx_bit_valid_out == $past(tx_bit_valid))
        else $error("tx valid not one cycle later");
    AST_RX_VALID_LAT: assert property (1'b1 |=> rx_bit_valid_out == $past(rx_bit_valid))
        else $error("rx valid not one cycle later");
    AST_TX_HOLD: assert property (!tx_bit_valid |=> $stable(tx_scr_kind) && $stable(tx_bit_out))
        else $error("tx selection moved without a bit");
    AST_RX_HOLD: assert property (!rx_bit_valid |=> $stable(rx_scr_kind) && $stable(rx_scr_invert))
        else $error("rx selection moved without a bit");
    AST_TX_INV_BIT: assert property (tx_bit_valid |=> tx_bit_out == ($past(tx_bit_in) ^ tx_scr_invert))
        else $error("tx bit inversion wrong");
    AST_INV_SELF: assert property (tx_scr_invert |-> tx_scr_kind inside {3'h0, 3'h1})
        else $error("inversion without self-sync scrambler");
endmodule // smsel_top_sva

bind smsel_top smsel_top_sva u_sva (.clock(clock), .resetn(resetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .tx_bit_valid(tx_bit_valid), .tx_bit_in(tx_bit_in), .tx_bit_valid_out(tx_bit_valid_out),
    .tx_bit_out(tx_bit_out), .tx_scr_kind(tx_scr_kind), .tx_scr_invert(tx_scr_invert),
    .rx_bit_valid(rx_bit_valid), .rx_bit_valid_out(rx_bit_valid_out), .rx_bit_out(rx_bit_out),
    .rx_scr_kind(rx_scr_kind), .rx_scr_invert(rx_scr_invert));

/* testbench.sv */
`include "smsel_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, resetn = 0, hsel = 0, hwrite = 0, run = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic        hreadyout, hresp, tv, tb, rv, rb, tvo, tbo, tinv, rvo, rbo, rinv, ptb, prb;
    logic [2:0]  tk, rk, rxm;
    logic [3:0]  etx = 0, erx = 0, rxo;
    int          err_count = 0, cmp_count = 0, seed = 39588;
    int          tc = 0, rc = 0;
    logic [3:0]  ltx = 0, lrx = 0;

    smsel_top u_dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .tx_bit_valid(tv),
        .tx_bit_in(tb), .tx_bit_valid_out(tvo), .tx_bit_out(tbo), .tx_scr_kind(tk),
        .tx_scr_invert(tinv), .rx_bit_valid(rv), .rx_bit_in(rb), .rx_bit_valid_out(rvo),
        .rx_bit_out(rbo), .rx_scr_kind(rk), .rx_scr_invert(rinv));
    smsel_bit_src u_src (.clock(clock), .run(run), .v_tx(tv), .b_tx(tb), .v_rx(rv), .b_rx(rb));

    always #5 clock = ~clock;

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task final_report;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // negedge sampling sees what the next rising edge will see
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(negedge clock); while (hreadyout !== 1'b1);
        @(posedge clock);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(negedge clock); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    // returns {invert, kind}
    function automatic logic [3:0] exp_sel(input logic [2:0] m, input logic [3:0] o);
        logic [2:0] s308, s309;
        s308 = o[1] ? 3'h2 : (o[2] ? 3'h3 : 3'h0);
        s309 = o[1] ? 3'h2 : 3'h0;
        case (m)
            3'h0: exp_sel = !o[0] ? {1'b0, o[3] ? s309 : s308} : (o[1] ? {1'b0, s308} : 4'h4);
            3'h1: exp_sel = {1'b0, s308};
            3'h2: exp_sel = {1'b0, s309};
            3'h3: exp_sel = 4'h1;
            3'h4: exp_sel = 4'h0;
            3'h5: exp_sel = 4'h9;
            3'h6: exp_sel = 4'h8;
            default: exp_sel = 4'h4;
        endcase
    endfunction

    always @(negedge clock)
    begin
        if (tvo === 1'b1)
        begin
            chk({31'h0, tbo}, {31'h0, ptb ^ etx[3]});
            chk({28'h0, tinv, tk}, {28'h0, etx});
        end
        if (rvo === 1'b1)
        begin
            chk({31'h0, rbo}, {31'h0, prb ^ erx[3]});
            chk({28'h0, rinv, rk}, {28'h0, erx});
        end
        ptb = tb;
        prb = rb;
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        err_count++;
        final_report;
    end

    initial
    begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        ahb(1'b0, `SMSEL_OFS_TX_MODE, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, `SMSEL_OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h0007_0000);
        ahb(1'b1, `SMSEL_OFS_STATUS, 32'hFFFF_FFFF, rd);
        ahb(1'b0, `SMSEL_OFS_STATUS, 32'h0, rd);
        chk(rd, 32'h0007_0000);
        ahb(1'b0, 8'h1C, 32'h0, rd);
        chk(rd, 32'h0);
        $display("reset and map test done");
        // every tx mode with every tx option set, rx random and independent
        for (int i = 0; i < 128; i++)
        begin
            rxm = 3'($random(seed));
            rxo = 4'($random(seed));
            ahb(1'b1, `SMSEL_OFS_TX_MODE, {29'h0, i[2:0]}, rd);
            ahb(1'b1, `SMSEL_OFS_RX_MODE, {29'h0, rxm}, rd);
            ahb(1'b1, `SMSEL_OFS_OPTIONS, {20'h0, rxo, 4'h0, i[6:3]}, rd);
            ahb(1'b0, `SMSEL_OFS_RX_MODE, 32'h0, rd);
            chk(rd, {29'h0, rxm});
            etx = exp_sel(i[2:0], i[6:3]);
            erx = exp_sel(rxm, rxo);
            // each run carries bits, so a new selection counts once per direction
            tc += (etx != ltx);
            rc += (erx != lrx);
            ltx = etx;
            lrx = erx;
            run <= 1'b1;
            repeat (24) @(posedge clock);
            run <= 1'b0;
            repeat (3) @(posedge clock);
        end
        $display("mode sweep test done");
        ahb(1'b0, `SMSEL_OFS_TX_CHG, 32'h0, rd);
        chk(rd, 32'(tc));
        ahb(1'b0, `SMSEL_OFS_RX_CHG, 32'h0, rd);
        chk(rd, 32'(rc));
        ahb(1'b1, `SMSEL_OFS_TX_CHG, 32'h0, rd);
        ahb(1'b0, `SMSEL_OFS_TX_CHG, 32'h0, rd);
        chk(rd, 32'h0);
        ahb(1'b0, `SMSEL_OFS_RX_CHG, 32'h0, rd);
        chk(rd, 32'(rc));
        $display("change counter test done");
        final_report;
    end
endmodule // testbench
